// ===== src/clockgen_map.svh
// offsets, field positions, reset values and timing counts of the clock generator control
`ifndef CLOCKGEN_MAP_SVH
`define CLOCKGEN_MAP_SVH

`define CLK_MHZ          100
`define WIN_US           350
`define WIN_CYC          (`WIN_US * `CLK_MHZ)
`define CNT_W            24

`define REG_FLAG         8'h00
`define REG_SPREAD       8'h04
`define REG_PWR          8'h0A
`define REG_ADDR         8'h0C
`define REG_OUT          8'h20

`define PWR_PDN          1
`define PWR_AUTOLOAD_DIS 2
`define PWR_RESAMPLE_DIS 3
`define PWR_IDLE_SEL     4
`define ADDR_LSB_SEL     15

`define OUT_OE0          0
`define OUT_OE1          1
`define PAGE_SPREAD      9

`define OUT_RESET        16'h0000
`define SPREAD_RESET     16'h0000
`define PWR_RESET        16'h0010
`define ADDR_RESET       16'hE800

`define PAGE0            16'h0000
`define PAGE1            16'h0203
`define PAGE2            16'h0057
`define PAGE3            16'h02AB

`define LSB_OFS0         7'h00
`define LSB_OFS1         7'h01
`define LSB_OFS2         7'h02
`define LSB_OFS3         7'h04

`define I2C_QTR          125

`endif

// ===== src/clockgen_pkg.sv
// state types shared by both ends of the clock generator control link
package clockgen_pkg;
	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_RUN    = 2'b01,
		ST_LOW    = 2'b11,
		ST_SETTLE = 2'b10
	} dev_state_e;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BIT   = 2'b11,
		H_STOP  = 2'b10
	} host_state_e;
endpackage

// ===== src/clockgen_link.sv
// pins between the board side host and the clock generator control
`timescale 1ns/100ps
interface clockgen_link;
	logic       supply_on;
	logic       mode_strap;
	logic       page_select_pin0;
	logic [1:0] address_strap_pin;
	logic       sda_host_out;
	logic       sda_host_oe;
	logic       sda_dev_out;
	logic       sda_dev_oe;
	wire        page_select_pin1;

	// open drain with pull-up: any enabled low driver wins
	assign page_select_pin1 = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));

	modport host (
		output supply_on,
		output mode_strap,
		output page_select_pin0,
		output address_strap_pin,
		output sda_host_out,
		output sda_host_oe,
		input  page_select_pin1
	);
	modport dev (
		input  supply_on,
		input  mode_strap,
		input  page_select_pin0,
		input  address_strap_pin,
		input  page_select_pin1,
		output sda_dev_out,
		output sda_dev_oe
	);
endinterface

// ===== src/pin_sync.sv
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ===== src/clockgen_device.sv
// device end: strap sampling, fuse page loading, low power and serial-bus write slave
// What this block does
// - strap high at power-up selects fuse-page mode
// - select pins choose one of four pages
// - new mode taken after supply cycle, select-change timeout or low-power exit resample
// - strap late after select change gives bus mode
// - select change reloads page, settles quickly
// - serial port disabled in fuse-page mode
// - bus mode: pins are bus clock, data
// - bus mode starts from page zero
// - power-down bit enters and leaves low power
// - idle select low, outputs off: low power
// - host enters low power before format changes
// - exit from low power resamples all straps
// - both disables set: registers kept on exit
// - autoload enabled, no resample: page zero reloaded
// - resample with strap high: fuse-page mode
// - fuse array fixed, programmed flag reads one
// - only output and spread fields differ per page
// - address from field MSBs plus strap LSBs
// - LSB select low: address field only
// - address strap not used as output enable
// - host sets power-down, writes, then clears
// - default two low-power outputs, both disabled
`timescale 1ns/100ps
`include "clockgen_map.svh"
module clockgen_device
	import clockgen_pkg::*;
#(
	parameter int WIN_CYC = `WIN_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	clockgen_link.dev        lnk,
	output logic             lowpower,
	output logic             bus_mode,
	output logic [1:0]       active_page,
	output logic             out0_enable,
	output logic             out1_enable,
	output logic [1:0]       ch0_output_format,
	output logic [1:0]       ch1_output_format,
	output logic [2:0]       spread_profile,
	output logic             spread_enable,
	output logic [6:0]       bus_address,
	output logic             fuse_programmed_flag
);
	localparam logic [15:0] PAGE_TAB [0:3] = '{`PAGE0, `PAGE1, `PAGE2, `PAGE3};

	logic [5:0]       pins;
	logic             supply_s;
	logic             strap_s;
	logic             scl_s;
	logic             sda_s;
	logic [1:0]       addr_s;
	logic [1:0]       addr_lat;
	logic [15:0]      reg_out;
	logic [15:0]      reg_spread;
	logic [15:0]      reg_pwr;
	logic [15:0]      reg_addr;
	logic [15:0]      pg;
	logic [`CNT_W-1:0] cnt;
	dev_state_e       state;
	dev_state_e       next_state;
	logic             load;
	logic [1:0]       load_page;
	logic             sample;
	logic             timeout;
	logic             low_req;
	logic             rs_dis;
	logic             al_dis;
	logic             wr_en;
	logic [7:0]       wr_idx;
	logic [15:0]      wr_data;
	logic             scl_q;
	logic             sda_q;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_c;
	logic             stop_c;
	logic             i_on;
	logic             i_ack;
	logic [3:0]       i_bit;
	logic [1:0]       i_byte;
	logic [7:0]       i_sh;
	logic [7:0]       i_idx;
	logic [7:0]       i_hi;
	logic [6:0]       lsb_ofs;

	// pins come from the board: two flops before any use
	pin_sync #(
		.W(6)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b  (rst_b),
		.d      ({lnk.supply_on, lnk.mode_strap, lnk.page_select_pin0, lnk.page_select_pin1, lnk.address_strap_pin}),
		.q      (pins)
	);
	assign {supply_s, strap_s, scl_s, sda_s, addr_s} = pins;

	assign rs_dis = reg_pwr[`PWR_RESAMPLE_DIS];
	assign al_dis = reg_pwr[`PWR_AUTOLOAD_DIS];
	// idle entry when outputs are off and idle select is low
	assign low_req = reg_pwr[`PWR_PDN] | (~reg_pwr[`PWR_IDLE_SEL] & ~reg_out[`OUT_OE0] & ~reg_out[`OUT_OE1]);
	assign pg = PAGE_TAB[load_page];

	always_comb begin
		next_state = state;
		load = 1'b0;
		load_page = 2'b00;
		sample = 1'b0;
		timeout = 1'b0;
		case (state)
			ST_OFF: begin
				// bus mode starts from page zero
				if (supply_s) begin
					sample = 1'b1;
					load = 1'b1;
					load_page = strap_s ? {sda_s, scl_s} : 2'b00;
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				// mode changes through supply off, settle timeout or resample on low-power exit
				if (!supply_s) begin
					next_state = ST_OFF;
				end else if (!bus_mode && {sda_s, scl_s} != active_page) begin
					next_state = ST_SETTLE;
				end else if (low_req) begin
					next_state = ST_LOW;
				end
			end
			ST_LOW: begin
				if (!supply_s) begin
					next_state = ST_OFF;
				end else if (!low_req) begin
					sample = ~rs_dis;
					load = (~rs_dis & strap_s) | ~al_dis;
					load_page = (~rs_dis & strap_s) ? {sda_s, scl_s} : 2'b00;
					next_state = ST_RUN;
				end
			end
			ST_SETTLE: begin
				if (!supply_s) begin
					next_state = ST_OFF;
				end else if (strap_s) begin
					// internal restart reloads the new page
					// strap in time switches the page
					load = 1'b1;
					load_page = {sda_s, scl_s};
					next_state = ST_RUN;
				end else if (cnt == `CNT_W'(WIN_CYC - 1)) begin
					// strap too late falls back to bus mode
					timeout = 1'b1;
					load = 1'b1;
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_OFF;
			lowpower <= 1'b0;
			cnt <= '0;
		end else begin
			state <= next_state;
			lowpower <= (next_state == ST_LOW);
			cnt <= (state == ST_SETTLE) ? cnt + 1'b1 : '0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_mode <= 1'b1;
			addr_lat <= 2'b00;
			active_page <= 2'b00;
		end else begin
			if (sample) begin
				bus_mode <= ~strap_s;
				addr_lat <= addr_s;
			end else if (timeout) begin
				bus_mode <= 1'b1;
			end
			if (load) begin
				active_page <= load_page;
			end
		end
	end

	// page load overrides a bus write in the same cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_out <= `OUT_RESET;
			reg_spread <= `SPREAD_RESET;
			reg_pwr <= `PWR_RESET;
			reg_addr <= `ADDR_RESET;
		end else if (load) begin
			// only output and spread fields per page
			reg_out <= {7'h00, pg[8:0]};
			reg_spread <= {15'h0000, pg[`PAGE_SPREAD]};
			reg_pwr <= `PWR_RESET;
			reg_addr <= `ADDR_RESET;
		end else if (wr_en) begin
			case (wr_idx)
				`REG_OUT: begin
					reg_out <= wr_data;
				end
				`REG_SPREAD: begin
					reg_spread <= wr_data;
				end
				`REG_PWR: begin
					reg_pwr <= wr_data;
				end
				`REG_ADDR: begin
					reg_addr <= wr_data;
				end
				default: begin
				end
			endcase
		end
	end

	assign out0_enable = reg_out[`OUT_OE0];
	assign out1_enable = reg_out[`OUT_OE1];
	assign ch0_output_format = reg_out[3:2];
	assign ch1_output_format = reg_out[5:4];
	assign spread_profile = reg_out[8:6];
	assign spread_enable = reg_spread[0];

	always_comb begin
		case (addr_lat)
			2'd0: lsb_ofs = `LSB_OFS0;
			2'd1: lsb_ofs = `LSB_OFS1;
			2'd2: lsb_ofs = `LSB_OFS2;
			default: lsb_ofs = `LSB_OFS3;
		endcase
	end

	// strap is latched, so a live strap wiggle cannot move the address mid-transfer
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_address <= 7'h00;
			fuse_programmed_flag <= 1'b1;
			lnk.sda_dev_out <= 1'b0;
		end else begin
			// LSB select low uses the field alone
			bus_address <= reg_addr[`ADDR_LSB_SEL] ? {reg_addr[14:10], 2'b00} + lsb_ofs : reg_addr[14:8];
			// fuse array is programmed for good
			fuse_programmed_flag <= 1'b1;
			lnk.sda_dev_out <= 1'b0;
		end
	end

	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

	// write-only slave: address, index, data high, data low, index advances
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			// same level as the synchroniser in reset, so no false start or stop follows release
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			i_on <= 1'b0;
			i_ack <= 1'b0;
			i_bit <= 4'h0;
			i_byte <= 2'h0;
			i_sh <= 8'h00;
			i_idx <= 8'h00;
			i_hi <= 8'h00;
			wr_en <= 1'b0;
			wr_idx <= 8'h00;
			wr_data <= 16'h0000;
			lnk.sda_dev_oe <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			wr_en <= 1'b0;
			// port held off in fuse-page mode
			if (!bus_mode || stop_c) begin
				i_on <= 1'b0;
				i_ack <= 1'b0;
				lnk.sda_dev_oe <= 1'b0;
			end else if (start_c) begin
				i_on <= 1'b1;
				i_ack <= 1'b0;
				i_bit <= 4'h0;
				i_byte <= 2'h0;
				lnk.sda_dev_oe <= 1'b0;
			end else if (i_on && scl_rise && i_bit != 4'h8) begin
				i_sh <= {i_sh[6:0], sda_s};
				i_bit <= i_bit + 4'h1;
			end else if (i_on && scl_fall && i_ack) begin
				i_ack <= 1'b0;
				i_bit <= 4'h0;
				lnk.sda_dev_oe <= 1'b0;
			end else if (i_on && scl_fall && i_bit == 4'h8) begin
				i_ack <= 1'b1;
				lnk.sda_dev_oe <= 1'b1;
				case (i_byte)
					2'd0: begin
						// answer only our own write address
						if (i_sh[7:1] != bus_address || i_sh[0]) begin
							i_on <= 1'b0;
							i_ack <= 1'b0;
							lnk.sda_dev_oe <= 1'b0;
						end else begin
							i_byte <= 2'd1;
						end
					end
					2'd1: begin
						i_idx <= i_sh;
						i_byte <= 2'd2;
					end
					2'd2: begin
						i_hi <= i_sh;
						i_byte <= 2'd3;
					end
					default: begin
						wr_en <= 1'b1;
						wr_idx <= i_idx;
						wr_data <= {i_hi, i_sh};
						i_idx <= i_idx + 8'h01;
						i_byte <= 2'd2;
					end
				endcase
			end
		end
	end
endmodule

// ===== src/clockgen_host.sv
// host end: board straps, supply switch and serial-bus write master
`timescale 1ns/100ps
`include "clockgen_map.svh"
module clockgen_host
	import clockgen_pkg::*;
#(
	parameter int QTR = `I2C_QTR
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	clockgen_link.host       lnk,
	input  wire logic        supply_en,
	input  wire logic        fuse_strap,
	input  wire logic        pins_mode,
	input  wire logic [1:0]  page_choice,
	input  wire logic [1:0]  addr_choice,
	input  wire logic        cmd_valid,
	input  wire logic [6:0]  cmd_dev_addr,
	input  wire logic [7:0]  cmd_reg,
	input  wire logic [15:0] cmd_data,
	output logic             cmd_busy,
	output logic             cmd_done,
	output logic             cmd_nack
);
	logic [15:0] div;
	logic        tick;
	logic        sda_s;
	host_state_e hs;
	logic [1:0]  ph;
	logic [3:0]  bit_n;
	logic [1:0]  byte_n;
	logic [7:0]  sh;
	logic [7:0]  nxt;
	logic [7:0]  reg_l;
	logic [15:0] data_l;

	pin_sync #(
		.W(1)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b  (rst_b),
		.d      (lnk.page_select_pin1),
		.q      (sda_s)
	);

	// bus clock is derived here: a quarter bit per tick
	assign tick = (div == 16'(QTR - 1));
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div <= 16'h0000;
		end else begin
			div <= tick ? 16'h0000 : div + 16'h0001;
		end
	end

	// straps and supply are plain board levels
	// address strap only ever drives address
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lnk.supply_on <= 1'b0;
			lnk.mode_strap <= 1'b0;
			lnk.address_strap_pin <= 2'b00;
			lnk.sda_host_out <= 1'b0;
		end else begin
			lnk.supply_on <= supply_en;
			lnk.mode_strap <= fuse_strap;
			lnk.address_strap_pin <= addr_choice;
			lnk.sda_host_out <= 1'b0;
		end
	end

	always_comb begin
		case (byte_n)
			2'd0: nxt = reg_l;
			2'd1: nxt = data_l[15:8];
			default: nxt = data_l[7:0];
		endcase
	end

	// user sequences power-down around format writes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hs <= H_IDLE;
			ph <= 2'd0;
			bit_n <= 4'h0;
			byte_n <= 2'd0;
			sh <= 8'h00;
			reg_l <= 8'h00;
			data_l <= 16'h0000;
			cmd_busy <= 1'b0;
			cmd_done <= 1'b0;
			cmd_nack <= 1'b0;
			lnk.page_select_pin0 <= 1'b1;
			lnk.sda_host_oe <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			case (hs)
				H_IDLE: begin
					// page pins driven directly in fuse-page use
					lnk.page_select_pin0 <= pins_mode ? page_choice[0] : 1'b1;
					lnk.sda_host_oe <= pins_mode & ~page_choice[1];
					if (cmd_valid && !pins_mode) begin
						sh <= {cmd_dev_addr, 1'b0};
						reg_l <= cmd_reg;
						data_l <= cmd_data;
						cmd_busy <= 1'b1;
						cmd_nack <= 1'b0;
						ph <= 2'd0;
						hs <= H_START;
					end
				end
				H_START: begin
					if (tick) begin
						ph <= ph + 2'd1;
						if (ph == 2'd0) begin
							lnk.sda_host_oe <= 1'b1;
						end else begin
							lnk.page_select_pin0 <= 1'b0;
							ph <= 2'd0;
							bit_n <= 4'h0;
							byte_n <= 2'd0;
							hs <= H_BIT;
						end
					end
				end
				H_BIT: begin
					if (tick) begin
						ph <= ph + 2'd1;
						case (ph)
							2'd0: lnk.sda_host_oe <= (bit_n != 4'h8) & ~sh[7];
							2'd1: lnk.page_select_pin0 <= 1'b1;
							2'd2: cmd_nack <= cmd_nack | ((bit_n == 4'h8) & sda_s);
							default: begin
								lnk.page_select_pin0 <= 1'b0;
								if (bit_n == 4'h8) begin
									bit_n <= 4'h0;
									sh <= nxt;
									byte_n <= byte_n + 2'd1;
									if (byte_n == 2'd3 || cmd_nack) begin
										hs <= H_STOP;
									end
								end else begin
									bit_n <= bit_n + 4'h1;
									sh <= {sh[6:0], 1'b0};
								end
							end
						endcase
					end
				end
				H_STOP: begin
					if (tick) begin
						ph <= ph + 2'd1;
						case (ph)
							2'd0: lnk.sda_host_oe <= 1'b1;
							2'd1: lnk.page_select_pin0 <= 1'b1;
							2'd2: lnk.sda_host_oe <= 1'b0;
							default: begin
								cmd_busy <= 1'b0;
								cmd_done <= 1'b1;
								hs <= H_IDLE;
							end
						endcase
					end
				end
				default: begin
					hs <= H_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== verification/clockgen_config_mode_control_properties.sv
// concurrent checks on the link between host and clock generator control
`timescale 1ns/100ps
module clockgen_config_mode_control_properties #(
	parameter int WIN_CYC = 50
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       supply_on,
	input  wire logic       mode_strap,
	input  wire logic       page_select_pin0,
	input  wire logic       page_select_pin1,
	input  wire logic [1:0] address_strap_pin,
	input  wire logic       sda_dev_oe,
	input  wire logic       bus_mode,
	input  wire logic [1:0] active_page,
	input  wire logic [6:0] bus_address,
	input  wire logic       fuse_programmed_flag
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	logic [1:0]  pins_q;
	logic [15:0] win_cnt;
	logic [5:0]  fuse_cnt;
	logic [6:0]  addr_exp;
	logic        pins_moved;

	assign pins_moved = {page_select_pin1, page_select_pin0} != pins_q;

	always_comb begin
		case (address_strap_pin)
			2'd0: addr_exp = 7'h68;
			2'd1: addr_exp = 7'h69;
			2'd2: addr_exp = 7'h6A;
			default: addr_exp = 7'h6C;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pins_q <= 2'h3;
		end else begin
			pins_q <= {page_select_pin1, page_select_pin0};
		end
	end

	// strap-low time since a select change; a supply cycle clears it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			win_cnt <= 16'h0000;
		end else if (bus_mode || mode_strap || !supply_on) begin
			win_cnt <= 16'h0000;
		end else if (pins_moved) begin
			win_cnt <= 16'h0001;
		end else if (win_cnt != 16'h0000 && win_cnt != 16'hFFFF) begin
			win_cnt <= win_cnt + 16'h0001;
		end
	end

	// a late ack may overlap the switch into fuse mode, so give it time
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			fuse_cnt <= 6'h00;
		end else if (bus_mode) begin
			fuse_cnt <= 6'h00;
		end else if (fuse_cnt != 6'h28) begin
			fuse_cnt <= fuse_cnt + 6'h01;
		end
	end

	sequence s_up_fuse;
		$rose(supply_on) && mode_strap ##1 (mode_strap && $stable({page_select_pin1, page_select_pin0}))[*6];
	endsequence
	sequence s_up_bus;
		$rose(supply_on) && !mode_strap ##1 (!mode_strap && $stable(address_strap_pin))[*6];
	endsequence
	sequence s_sel_move;
		!bus_mode && mode_strap && supply_on && pins_moved ##1 (mode_strap && supply_on && !pins_moved)[*8];
	endsequence

	property p_flag;
		fuse_programmed_flag;
	endproperty
	property p_up_fuse;
		s_up_fuse |-> !bus_mode && active_page == {page_select_pin1, page_select_pin0};
	endproperty
	property p_up_bus;
		s_up_bus |-> bus_mode && active_page == 2'd0 && bus_address == addr_exp;
	endproperty
	property p_sel_move;
		s_sel_move |-> active_page == {page_select_pin1, page_select_pin0};
	endproperty
	property p_win_late;
		win_cnt <= WIN_CYC + 12;
	endproperty
	property p_win_early;
		$rose(bus_mode) && win_cnt != 16'h0000 |-> win_cnt >= WIN_CYC;
	endproperty
	property p_ack_start;
		$rose(sda_dev_oe) |-> bus_mode && !page_select_pin0 && $past(page_select_pin0, 6);
	endproperty
	property p_ack_hold;
		$rose(page_select_pin0) && sda_dev_oe |-> sda_dev_oe[*4];
	endproperty
	property p_fuse_quiet;
		fuse_cnt >= 6'h1E |-> !sda_dev_oe;
	endproperty

	a_flag: assert property (p_flag) else $error("programmed flag not set");
	a_up_fuse: assert property (p_up_fuse) else $error("fuse power-up wrong page");
	a_up_bus: assert property (p_up_bus) else $error("bus power-up wrong state");
	a_sel_move: assert property (p_sel_move) else $error("page not switched");
	a_win_late: assert property (p_win_late) else $error("window expiry missed");
	a_win_early: assert property (p_win_early) else $error("bus mode before window end");
	a_ack_start: assert property (p_ack_start) else $error("ack not after clock fall");
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped while clock high");
	a_fuse_quiet: assert property (p_fuse_quiet) else $error("data driven in fuse mode");
endmodule

// ===== verification/clockgen_config_mode_control_tb_top.sv
// self-checking bench joining host and device ends of the clock generator control
`timescale 1ns/100ps
`include "clockgen_map.svh"
module clockgen_config_mode_control_tb_top;
	localparam int WIN = 50;
	localparam logic [15:0] PAGE_TAB [4] = '{`PAGE0, `PAGE1, `PAGE2, `PAGE3};
	localparam logic [15:0] ADDR_TAB [4] = '{16'h0068, 16'h0069, 16'h006A, 16'h006C};
	logic        ref_clk;
	logic        rst_b;
	logic        supply_en;
	logic        fuse_strap;
	logic        pins_mode;
	logic [1:0]  page_choice;
	logic [1:0]  addr_choice;
	logic        cmd_valid;
	logic [6:0]  cmd_dev_addr;
	logic [7:0]  cmd_reg;
	logic [15:0] cmd_data;
	logic        cmd_busy;
	logic        cmd_done;
	logic        cmd_nack;
	logic        lowpower;
	logic        bus_mode;
	logic [1:0]  active_page;
	logic        out0_enable;
	logic        out1_enable;
	logic [1:0]  ch0_output_format;
	logic [1:0]  ch1_output_format;
	logic [2:0]  spread_profile;
	logic        spread_enable;
	logic [6:0]  bus_address;
	logic        fuse_programmed_flag;
	int          err_count = 0;
	int          total_checks = 0;
	int          cycles = 0;

	clockgen_link lnk ();
	clockgen_host #(.QTR(4)) clockgen_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk),
		.supply_en(supply_en), .fuse_strap(fuse_strap), .pins_mode(pins_mode), .page_choice(page_choice),
		.addr_choice(addr_choice), .cmd_valid(cmd_valid), .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg),
		.cmd_data(cmd_data), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_nack(cmd_nack));
	clockgen_device #(.WIN_CYC(WIN)) clockgen_device_i (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk),
		.lowpower(lowpower), .bus_mode(bus_mode), .active_page(active_page), .out0_enable(out0_enable),
		.out1_enable(out1_enable), .ch0_output_format(ch0_output_format), .ch1_output_format(ch1_output_format),
		.spread_profile(spread_profile), .spread_enable(spread_enable), .bus_address(bus_address),
		.fuse_programmed_flag(fuse_programmed_flag));
	clockgen_config_mode_control_properties #(.WIN_CYC(WIN)) clockgen_config_mode_control_properties_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .supply_on(lnk.supply_on), .mode_strap(lnk.mode_strap),
		.page_select_pin0(lnk.page_select_pin0), .page_select_pin1(lnk.page_select_pin1),
		.address_strap_pin(lnk.address_strap_pin), .sda_dev_oe(lnk.sda_dev_oe), .bus_mode(bus_mode),
		.active_page(active_page), .bus_address(bus_address), .fuse_programmed_flag(fuse_programmed_flag));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic give_verdict;
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	function automatic logic [15:0] cfg();
		return {6'h00, spread_enable, spread_profile, ch1_output_format, ch0_output_format, out1_enable, out0_enable};
	endfunction

	// supply held off long enough to count as a power cycle
	task automatic power(input logic strap, input logic [1:0] page, input logic [1:0] addr);
		supply_en = 1'b0;
		tick(8);
		fuse_strap = strap;
		pins_mode = strap;
		page_choice = page;
		addr_choice = addr;
		tick(2);
		supply_en = 1'b1;
		tick(12);
	endtask

	task automatic bus_write(input logic [6:0] dev, input logic [7:0] idx, input logic [15:0] data, input logic nack);
		int n;
		cmd_dev_addr = dev;
		cmd_reg = idx;
		cmd_data = data;
		cmd_valid = 1'b1;
		n = 0;
		while (cmd_busy !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
		cmd_valid = 1'b0;
		n = 0;
		while (cmd_done !== 1'b1 && n < 2000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check(16'(cmd_done), 16'h0001);
		check(16'(cmd_nack), 16'(nack));
		tick(4);
	endtask

	task automatic fuse_pages;
		for (int p = 0; p < 4; p++) begin
			power(1'b1, 2'(p), 2'd1);
			check(16'(bus_mode), 16'h0000);
			check(16'(active_page), 16'(p));
			check(cfg(), PAGE_TAB[p] & 16'h03FF);
			check(16'(bus_address), 16'h0069);
		end
	endtask

	task automatic page_switch;
		power(1'b1, 2'd1, 2'd0);
		page_choice = 2'd3;
		tick(20);
		check(cfg(), `PAGE3 & 16'h03FF);
		fuse_strap = 1'b0;
		page_choice = 2'd0;
		tick(20);
		fuse_strap = 1'b1;
		tick(15);
		check(16'(bus_mode), 16'h0000);
		check(16'(active_page), 16'h0000);
		fuse_strap = 1'b0;
		page_choice = 2'd2;
		tick(WIN + 20);
		check(16'(bus_mode), 16'h0001);
		check(16'(active_page), 16'h0000);
	endtask

	task automatic bus_regs;
		for (int a = 0; a < 4; a++) begin
			power(1'b0, 2'd0, 2'(a));
			check(16'(bus_mode), 16'h0001);
			check(cfg(), 16'h0000);
			check(16'(bus_address), ADDR_TAB[a]);
		end
		fuse_strap = 1'b1;
		tick(10);
		check(16'(bus_mode), 16'h0001);
		fuse_strap = 1'b0;
		bus_write(7'h6C, `REG_ADDR, 16'h5500, 1'b0);
		check(16'(bus_address), 16'h0055);
		bus_write(7'h6C, `REG_SPREAD, 16'h0001, 1'b1);
		check(16'(spread_enable), 16'h0000);
		bus_write(7'h55, `REG_SPREAD, 16'h0001, 1'b0);
		check(16'(spread_enable), 16'h0001);
		bus_write(7'h55, `REG_FLAG, 16'h0000, 1'b0);
		check(16'(fuse_programmed_flag), 16'h0001);
	endtask

	// host keeps the power-down, write, release order around the 16'h01B5 output write only
	task automatic low_power;
		power(1'b0, 2'd0, 2'd0);
		bus_write(7'h68, `REG_PWR, 16'h001E, 1'b0);
		check(16'(lowpower), 16'h0001);
		bus_write(7'h68, `REG_OUT, 16'h01B5, 1'b0);
		bus_write(7'h68, `REG_PWR, 16'h001C, 1'b0);
		check(16'(lowpower), 16'h0000);
		check(cfg(), 16'h01B5);
		bus_write(7'h68, `REG_PWR, 16'h001A, 1'b0);
		bus_write(7'h68, `REG_PWR, 16'h0018, 1'b0);
		check(cfg(), 16'h0000);
		check(16'(lowpower), 16'h0000);
		bus_write(7'h68, `REG_PWR, 16'h0000, 1'b0);
		check(16'(lowpower), 16'h0001);
		bus_write(7'h68, `REG_OUT, 16'h0003, 1'b0);
		check(16'(lowpower), 16'h0000);
		check(16'(bus_mode), 16'h0001);
		check(cfg(), 16'h0000);
		bus_write(7'h68, `REG_PWR, 16'h0012, 1'b0);
		fuse_strap = 1'b1;
		tick(5);
		// port shuts during this ack as the strap takes the device into fuse-page mode
		bus_write(7'h68, `REG_PWR, 16'h0010, 1'b1);
		check(16'(bus_mode), 16'h0000);
		pins_mode = 1'b1;
		page_choice = 2'd1;
		tick(20);
		check(cfg(), `PAGE1 & 16'h03FF);
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		rst_b = 1'b0;
		supply_en = 1'b0;
		fuse_strap = 1'b0;
		pins_mode = 1'b0;
		page_choice = 2'd0;
		addr_choice = 2'd0;
		cmd_valid = 1'b0;
		cmd_dev_addr = 7'h00;
		cmd_reg = 8'h00;
		cmd_data = 16'h0000;
		tick(4);
		rst_b = 1'b1;
		tick(2);
		fuse_pages();
		page_switch();
		bus_regs();
		low_power();
		give_verdict();
	end
endmodule
